// File: rtl/rcs_pkg.sv
// constants for the reset-cause and register-initialisation block
// assumes a single core clock; event inputs are one-cycle pulses from the core
package rcs_pkg;
    // ************************************************
    // register bus offsets
    // ************************************************
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_STACK = 8'h01;
    localparam logic [7:0] ADDR_PC_LO = 8'h02;
    localparam logic [7:0] ADDR_PC_HI = 8'h03;
    localparam logic [7:0] ADDR_PC_UP = 8'h04;
    localparam logic [7:0] ADDR_INTC0 = 8'h05;
    localparam logic [7:0] ADDR_INTC2 = 8'h06;
    localparam logic [7:0] ADDR_INTC3 = 8'h07;
    localparam logic [7:0] ADDR_BANK = 8'h08;
    localparam logic [7:0] ADDR_TBLAT = 8'h09;
    localparam logic [7:0] ADDR_CTRL = 8'h0A;
    // ************************************************
    // cause register bit positions
    // ************************************************
    localparam int BIT_BROWN = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_PDOWN = 2;
    localparam int BIT_WDTO = 3;
    localparam int BIT_RINST = 4;
    localparam int BIT_CFGM = 5;
    localparam int BIT_SUNF = 6;
    localparam int BIT_SFUL = 7;
    // ************************************************
    // reset values
    // ************************************************
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [7:0] INTC0_RST = 8'h00;
    localparam logic [7:0] INTC2_RST = 8'hFF;
    localparam logic [7:0] INTC3_RST = 8'hC0;
    localparam logic [4:0] SP_RST = 5'h00;
    localparam logic [7:0] CAUSE_POR_VAL = 8'h3C;
    localparam int CTRL_STKRST = 0;
    localparam int CTRL_GIE_HI = 1;
    localparam int CTRL_GIE_LO = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    // power modes
    typedef enum logic [1:0] {MODE_FULL, MODE_RUN, MODE_IDLE, MODE_SLEEP} rcs_mode_t;
endpackage : rcs_pkg

// File: rtl/rcs_core.sv
// reset-cause recorder and core register reset-value logic
// assumes event pulses are one core_clk cycle and synchronous; power-on comes on rst
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module rcs_core
    import rcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // events
    input wire logic brownout_evt,
    input wire logic reset_instr_evt,
    input wire logic config_mismatch_evt,
    input wire logic external_reset_pin_evt,
    input wire logic stack_full_evt,
    input wire logic stack_underflow_evt,
    input wire logic watchdog_evt,
    input wire logic int_wake_evt,
    input wire logic int_high_prio,
    input wire logic sleep_instr_evt,
    input wire logic watchdog_clear_instruction,
    input wire rcs_mode_t power_mode,
    input wire logic [20:0] cur_pc,
    // register bus
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // core outputs
    output logic [20:0] pc_load,
    output logic pc_load_valid,
    output logic core_reset,
    output logic [7:0] reset_cause_register,
    output logic stack_full_flag,
    output logic stack_underflow_flag
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [7:0] cause;
        logic [4:0] sp;
        logic [1:0] sp_top;
        logic [20:0] tos;
        logic [20:0] pc;
        logic [4:0] pclat_u;
        logic [7:0] pclat_h;
        logic [21:0] tblptr;
        logic [7:0] tblat;
        logic [3:0] bank;
        logic [7:0] intc0;
        logic [7:0] intc2;
        logic [7:0] intc3;
        logic [2:0] ctrl;
        logic pc_valid;
        logic hard;
        logic [7:0] rdata;
    } rcs_state_t;

    rcs_state_t st_r;
    rcs_state_t st_nxt;

    logic low_sleep;
    logic hard_evt;
    logic wdt_wake;
    logic gie;

    assign low_sleep = (power_mode == MODE_IDLE) || (power_mode == MODE_SLEEP);
    assign wdt_wake = watchdog_evt && low_sleep;
    assign hard_evt = brownout_evt || reset_instr_evt || config_mismatch_evt || external_reset_pin_evt
        || (watchdog_evt && !low_sleep)
        || (st_r.ctrl[CTRL_STKRST] && (stack_full_evt || stack_underflow_evt));
    assign gie = st_r.ctrl[CTRL_GIE_HI] || st_r.ctrl[CTRL_GIE_LO];

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.pc_valid = 1'b0;
        st_nxt.hard = 1'b0;
        st_nxt.rdata = 8'h00;
        // software writes; hardware events below win
        if (bus_wr) begin
            case (bus_addr)
                ADDR_CAUSE: st_nxt.cause[BIT_CFGM:BIT_BROWN] = bus_wdata[BIT_CFGM:BIT_BROWN];
                ADDR_STACK: begin
                    st_nxt.cause[BIT_SFUL] = bus_wdata[BIT_SFUL];
                    st_nxt.cause[BIT_SUNF] = bus_wdata[BIT_SUNF];
                    st_nxt.sp = bus_wdata[4:0];
                end
                ADDR_INTC0: st_nxt.intc0 = bus_wdata;
                ADDR_INTC2: st_nxt.intc2 = bus_wdata;
                ADDR_INTC3: st_nxt.intc3 = bus_wdata;
                ADDR_BANK: st_nxt.bank = bus_wdata[3:0];
                ADDR_TBLAT: st_nxt.tblat = bus_wdata;
                ADDR_CTRL: st_nxt.ctrl = bus_wdata[2:0];
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end
        if (sleep_instr_evt) begin
            st_nxt.cause[BIT_PDOWN] = 1'b0;
            st_nxt.cause[BIT_WDTO] = 1'b1;
        end
        if (watchdog_clear_instruction) begin
            st_nxt.cause[BIT_PDOWN] = 1'b1;
            st_nxt.cause[BIT_WDTO] = 1'b1;
        end
        // flags change once, on the event cycle
        if (brownout_evt) begin
            st_nxt.cause[BIT_CFGM] = 1'b1;
            st_nxt.cause[BIT_RINST] = 1'b1;
            st_nxt.cause[BIT_WDTO] = 1'b1;
            st_nxt.cause[BIT_PDOWN] = 1'b1;
            st_nxt.cause[BIT_BROWN] = 1'b0;
        end
        if (reset_instr_evt) begin
            st_nxt.cause[BIT_RINST] = 1'b0;
        end
        if (config_mismatch_evt) begin
            st_nxt.cause[BIT_CFGM] = 1'b0;
        end
        if (external_reset_pin_evt && power_mode != MODE_FULL) begin
            st_nxt.cause[BIT_WDTO] = 1'b1;
            if (low_sleep) begin
                st_nxt.cause[BIT_PDOWN] = 1'b0;
            end
        end
        if (stack_full_evt && st_r.ctrl[CTRL_STKRST]) begin
            st_nxt.cause[BIT_SFUL] = 1'b1;
        end
        if (stack_underflow_evt) begin
            st_nxt.cause[BIT_SUNF] = 1'b1;
        end
        if (watchdog_evt) begin
            st_nxt.cause[BIT_WDTO] = 1'b0;
            if (low_sleep) begin
                st_nxt.cause[BIT_PDOWN] = 1'b0;
            end
        end
        if (int_wake_evt && power_mode != MODE_FULL && !hard_evt) begin
            st_nxt.cause[BIT_PDOWN] = 1'b0;
        end
        if (hard_evt) begin
            st_nxt.pc = PC_RESET;
            st_nxt.pc_valid = 1'b1;
            st_nxt.hard = 1'b1;
            st_nxt.tos = PC_RESET;
            st_nxt.sp = SP_RST;
            st_nxt.pclat_u = 5'h00;
            st_nxt.pclat_h = 8'h00;
            st_nxt.tblptr = 22'h000000;
            st_nxt.tblat = 8'h00;
            st_nxt.bank = 4'h0;
            st_nxt.intc0 = {INTC0_RST[7:1], st_r.intc0[0]};
            st_nxt.intc2 = INTC2_RST;
            st_nxt.intc3 = INTC3_RST;
            st_nxt.ctrl[CTRL_GIE_HI] = 1'b0;
            st_nxt.ctrl[CTRL_GIE_LO] = 1'b0;
        end else if (wdt_wake || (int_wake_evt && power_mode != MODE_FULL)) begin
            st_nxt.pc_valid = 1'b1;
            st_nxt.pc = 21'(cur_pc + PC_STEP);
            if (int_wake_evt && gie) begin
                st_nxt.tos = 21'(cur_pc + PC_STEP);
                // the pointer wraps silently; overflow is the stack logic's concern
                st_nxt.sp = 5'(st_r.sp + 5'h01);
                st_nxt.pc = int_high_prio ? VEC_HIGH : VEC_LOW;
            end
        end
        st_nxt.sp_top = {st_nxt.cause[BIT_SFUL], st_nxt.cause[BIT_SUNF]};
        if (bus_rd) begin
            case (bus_addr)
                ADDR_CAUSE: st_nxt.rdata = {2'b00, st_r.cause[BIT_CFGM:BIT_BROWN]};
                ADDR_STACK: st_nxt.rdata = {st_r.sp_top, 1'b0, st_r.sp};
                ADDR_PC_LO: st_nxt.rdata = st_r.pc[7:0];
                ADDR_PC_HI: st_nxt.rdata = st_r.pc[15:8];
                ADDR_PC_UP: st_nxt.rdata = {3'b000, st_r.pc[20:16]};
                ADDR_INTC0: st_nxt.rdata = st_r.intc0;
                ADDR_INTC2: st_nxt.rdata = st_r.intc2;
                ADDR_INTC3: st_nxt.rdata = st_r.intc3;
                ADDR_BANK: st_nxt.rdata = {4'h0, st_r.bank};
                ADDR_TBLAT: st_nxt.rdata = st_r.tblat;
                ADDR_CTRL: st_nxt.rdata = {5'h00, st_r.ctrl};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ************************************************
    // registers
    // ************************************************
    // power-on values; unknown-content registers get zero here for determinism
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.cause <= CAUSE_POR_VAL;
            st_r.intc2 <= INTC2_RST;
            st_r.intc3 <= INTC3_RST;
            st_r.ctrl <= CTRL_RST;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata = st_r.rdata;
    assign pc_load = st_r.pc;
    assign pc_load_valid = st_r.pc_valid;
    assign core_reset = st_r.hard;
    assign reset_cause_register = {2'b00, st_r.cause[BIT_CFGM:BIT_BROWN]};
    assign stack_full_flag = st_r.cause[BIT_SFUL];
    assign stack_underflow_flag = st_r.cause[BIT_SUNF];

    // ************************************************
    // checks
    // ************************************************
    // wake requests are shared by several checks below
    sequence s_int_wake_req;
        clk_en && int_wake_evt && (power_mode != MODE_FULL) && !hard_evt;
    endsequence
    sequence s_wdt_wake_req;
        clk_en && wdt_wake && !hard_evt;
    endsequence
    property p_bor;
        @(posedge core_clk) disable iff (rst)
        (clk_en && brownout_evt && !config_mismatch_evt)
            |=> (st_r.cause[BIT_BROWN] == 1'b0) && st_r.cause[BIT_CFGM] && (st_r.pc == PC_RESET);
    endproperty
    a_bor: assert property (p_bor) else $error("brownout values wrong");
    property p_ri;
        @(posedge core_clk) disable iff (rst)
        (clk_en && reset_instr_evt && !brownout_evt) |=> !st_r.cause[BIT_RINST] && core_reset;
    endproperty
    a_ri: assert property (p_ri) else $error("reset instruction flag not cleared");
    property p_pin_full;
        @(posedge core_clk) disable iff (rst)
        (clk_en && external_reset_pin_evt && power_mode == MODE_FULL && !brownout_evt && !reset_instr_evt
            && !config_mismatch_evt && !watchdog_evt && !sleep_instr_evt && !watchdog_clear_instruction
            && !stack_full_evt && !stack_underflow_evt && !bus_wr) |=> $stable(st_r.cause);
    endproperty
    a_pin_full: assert property (p_pin_full) else $error("pin reset changed flags");
    property p_unf_nores;
        @(posedge core_clk) disable iff (rst)
        (clk_en && stack_underflow_evt && !st_r.ctrl[CTRL_STKRST] && !hard_evt) |=> stack_underflow_flag && !core_reset;
    endproperty
    a_unf_nores: assert property (p_unf_nores) else $error("underflow without enable wrong");
    property p_wdt_run;
        @(posedge core_clk) disable iff (rst)
        (clk_en && watchdog_evt && !low_sleep) |=> !st_r.cause[BIT_WDTO] && core_reset && pc_load == PC_RESET;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset wrong");
    property p_wdt_wake;
        @(posedge core_clk) disable iff (rst)
        s_wdt_wake_req ##0 !int_wake_evt |=> pc_load == 21'($past(cur_pc) + PC_STEP) && !core_reset;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake pc wrong");
    // the watchdog is applied after every event but the interrupt wake, which only clears power-down, so both flags end low
    property p_wdt_wake_flags;
        @(posedge core_clk) disable iff (rst)
        (clk_en && wdt_wake) |=> !st_r.cause[BIT_WDTO] && !st_r.cause[BIT_PDOWN];
    endproperty
    a_wdt_wake_flags: assert property (p_wdt_wake_flags) else $error("watchdog wake flags wrong");
    property p_vec;
        @(posedge core_clk) disable iff (rst)
        s_int_wake_req ##0 gie |=> pc_load == ($past(int_high_prio) ? VEC_HIGH : VEC_LOW);
    endproperty
    a_vec: assert property (p_vec) else $error("interrupt vector wrong");
    property p_vec_push;
        @(posedge core_clk) disable iff (rst)
        s_int_wake_req ##0 gie |=> st_r.tos == 21'($past(cur_pc) + PC_STEP);
    endproperty
    a_vec_push: assert property (p_vec_push) else $error("return address not pushed");
    property p_int_wake;
        @(posedge core_clk) disable iff (rst)
        s_int_wake_req ##0 !watchdog_clear_instruction |=> !st_r.cause[BIT_PDOWN] && pc_load_valid && !core_reset;
    endproperty
    a_int_wake: assert property (p_int_wake) else $error("interrupt wake wrong");
    property p_cm;
        @(posedge core_clk) disable iff (rst)
        (clk_en && config_mismatch_evt) |=> !st_r.cause[BIT_CFGM] && core_reset && pc_load == PC_RESET;
    endproperty
    a_cm: assert property (p_cm) else $error("mismatch flag not cleared");
    property p_pin_run;
        @(posedge core_clk) disable iff (rst)
        (clk_en && external_reset_pin_evt && power_mode == MODE_RUN && !watchdog_evt)
            |=> st_r.cause[BIT_WDTO] && core_reset && pc_load == PC_RESET;
    endproperty
    a_pin_run: assert property (p_pin_run) else $error("pin reset in run wrong");
    property p_pin_sleep;
        @(posedge core_clk) disable iff (rst)
        (clk_en && external_reset_pin_evt && low_sleep && !watchdog_evt)
            |=> st_r.cause[BIT_WDTO] && !st_r.cause[BIT_PDOWN] && core_reset;
    endproperty
    a_pin_sleep: assert property (p_pin_sleep) else $error("pin reset in sleep wrong");
    property p_sfull;
        @(posedge core_clk) disable iff (rst)
        (clk_en && stack_full_evt && st_r.ctrl[CTRL_STKRST]) |=> stack_full_flag && core_reset && pc_load == PC_RESET;
    endproperty
    a_sfull: assert property (p_sfull) else $error("stack full reset wrong");
    property p_sunf_rst;
        @(posedge core_clk) disable iff (rst)
        (clk_en && stack_underflow_evt && st_r.ctrl[CTRL_STKRST]) |=> stack_underflow_flag && core_reset;
    endproperty
    a_sunf_rst: assert property (p_sunf_rst) else $error("stack underflow reset wrong");
    property p_sleep;
        @(posedge core_clk) disable iff (rst)
        (clk_en && sleep_instr_evt && !watchdog_clear_instruction && !brownout_evt) |=> !st_r.cause[BIT_PDOWN];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not clear power-down");
    property p_watchdog_clear_instruction;
        @(posedge core_clk) disable iff (rst)
        (clk_en && watchdog_clear_instruction && !external_reset_pin_evt && !watchdog_evt && !int_wake_evt)
            |=> st_r.cause[BIT_PDOWN] && st_r.cause[BIT_WDTO];
    endproperty
    a_watchdog_clear_instruction: assert property (p_watchdog_clear_instruction) else $error("watchdog clear flags wrong");
    property p_hard_regs;
        @(posedge core_clk) disable iff (rst)
        (clk_en && hard_evt) |=> st_r.bank == 4'h0 && st_r.tblat == 8'h00 && st_r.tblptr == 22'h000000
            && st_r.pclat_u == 5'h00 && st_r.pclat_h == 8'h00 && st_r.tos == PC_RESET && st_r.sp == SP_RST;
    endproperty
    a_hard_regs: assert property (p_hard_regs) else $error("hard reset registers wrong");
    property p_wake_keep;
        @(posedge core_clk) disable iff (rst)
        s_wdt_wake_req ##0 (!int_wake_evt && !bus_wr)
            |=> $stable(st_r.bank) && $stable(st_r.tblat) && $stable(st_r.intc2) && $stable(st_r.sp);
    endproperty
    a_wake_keep: assert property (p_wake_keep) else $error("watchdog wake touched registers");
    // a low enable must freeze everything, pulses included
    property p_hold;
        @(posedge core_clk) disable iff (rst)
        !clk_en |=> $stable(st_r);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while frozen");
    property p_reset_pulse;
        @(posedge core_clk) disable iff (rst)
        (clk_en && core_reset && !hard_evt) |=> !core_reset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("core reset longer than one cycle");
    property p_intc;
        @(posedge core_clk) disable iff (rst)
        (clk_en && hard_evt) |=> st_r.intc2 == INTC2_RST && st_r.intc3 == INTC3_RST && st_r.intc0[0] == $past(st_r.intc0[0]);
    endproperty
    a_intc: assert property (p_intc) else $error("interrupt control reset wrong");
endmodule : rcs_core

// File: bench/reset_cause_status_logic_tb.sv
// self-checking bench for the reset-cause recorder
// assumes rcs_core drives registered outputs one cycle after each event or bus strobe
`timescale 1ns/100ps
module reset_cause_status_logic_tb
    import rcs_pkg::*;
;
    // ************************************************
    // stimulus and observed signals
    // ************************************************
    typedef struct packed {
        logic [3:0] ev;
        rcs_mode_t mode;
        logic [7:0] pre;
        logic [7:0] cause;
        logic [1:0] stk;
        logic rs;
        logic [20:0] pc;
        logic pv;
    } rcs_row_t;
    localparam logic [20:0] CPC = 21'h01F3E0;
    localparam logic [20:0] WPC = 21'h01F3E2;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [9:0] ev_v = 10'h000;
    logic int_high_prio = 1'b0;
    rcs_mode_t power_mode = MODE_FULL;
    logic [20:0] cur_pc = CPC;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic [20:0] pc_load;
    logic pc_load_valid;
    logic core_reset;
    logic [7:0] reset_cause_register;
    logic stack_full_flag;
    logic stack_underflow_flag;
    int bad_count = 0;
    int checks = 0;
    // event index: 0 brownout 1 reset instr 2 mismatch 3 pin 4 full 5 underflow 6 watchdog 7 int wake
    rcs_row_t rows [0:14] = '{
        '{4'd4, MODE_FULL, 8'h3F, 8'h3F, 2'b10, 1'b1, PC_RESET, 1'b1},
        '{4'd5, MODE_FULL, 8'h3F, 8'h3F, 2'b01, 1'b1, PC_RESET, 1'b1},
        '{4'd0, MODE_FULL, 8'h03, 8'h3E, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd1, MODE_FULL, 8'h3F, 8'h2F, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd2, MODE_FULL, 8'h3F, 8'h1F, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd3, MODE_RUN, 8'h00, 8'h08, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd3, MODE_IDLE, 8'h04, 8'h08, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd3, MODE_SLEEP, 8'h3F, 8'h3B, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd3, MODE_FULL, 8'h15, 8'h15, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd6, MODE_FULL, 8'h3F, 8'h37, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd6, MODE_RUN, 8'h2C, 8'h24, 2'b00, 1'b1, PC_RESET, 1'b1},
        '{4'd6, MODE_IDLE, 8'h3F, 8'h33, 2'b00, 1'b0, WPC, 1'b1},
        '{4'd6, MODE_SLEEP, 8'h0C, 8'h00, 2'b00, 1'b0, WPC, 1'b1},
        '{4'd7, MODE_IDLE, 8'h3F, 8'h3B, 2'b00, 1'b0, WPC, 1'b1},
        '{4'd7, MODE_SLEEP, 8'h08, 8'h08, 2'b00, 1'b0, WPC, 1'b1}
    };

    rcs_core dut (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .brownout_evt(ev_v[0]), .reset_instr_evt(ev_v[1]), .config_mismatch_evt(ev_v[2]),
        .external_reset_pin_evt(ev_v[3]), .stack_full_evt(ev_v[4]), .stack_underflow_evt(ev_v[5]),
        .watchdog_evt(ev_v[6]), .int_wake_evt(ev_v[7]), .int_high_prio(int_high_prio),
        .sleep_instr_evt(ev_v[8]), .watchdog_clear_instruction(ev_v[9]),
        .power_mode(power_mode), .cur_pc(cur_pc),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .pc_load(pc_load), .pc_load_valid(pc_load_valid),
        .core_reset(core_reset), .reset_cause_register(reset_cause_register),
        .stack_full_flag(stack_full_flag), .stack_underflow_flag(stack_underflow_flag)
    );

    always #5 core_clk = ~core_clk;

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        @(negedge core_clk);
        chk("bus_rdata", e, bus_rdata);
    endtask : rd

    task automatic pulse(input int i);
        @(posedge core_clk);
        ev_v <= 10'h001 << i;
        @(posedge core_clk);
        ev_v <= 10'h000;
        @(negedge core_clk);
    endtask : pulse

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // ************************************************
    // hang guard
    // ************************************************
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        close_out();
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(ADDR_CAUSE, CAUSE_POR_VAL);
        rd(ADDR_STACK, 8'h00);
        rd(ADDR_INTC0, INTC0_RST);
        rd(ADDR_INTC2, INTC2_RST);
        rd(ADDR_INTC3, INTC3_RST);
        rd(ADDR_BANK, 8'h00);
        rd(ADDR_CTRL, 8'h01);
        rd(8'hFF, 8'h00);
        foreach (rows[i]) begin
            wr(ADDR_CAUSE, rows[i].pre);
            wr(ADDR_STACK, 8'h00);
            power_mode <= rows[i].mode;
            pulse(rows[i].ev);
            chk("cause", rows[i].cause, reset_cause_register);
            chk("stack_flags", rows[i].stk, {stack_full_flag, stack_underflow_flag});
            chk("core_reset", rows[i].rs, core_reset);
            chk("pc_load_valid", rows[i].pv, pc_load_valid);
            chk("pc_load", rows[i].pc, pc_load);
        end
        // vectored wake with interrupts enabled, then a hard reset
        wr(ADDR_BANK, 8'h05);
        wr(ADDR_TBLAT, 8'hA5);
        wr(ADDR_STACK, 8'h00);
        wr(ADDR_CTRL, 8'h03);
        power_mode <= MODE_SLEEP;
        int_high_prio <= 1'b1;
        pulse(7);
        chk("pc_load", VEC_HIGH, pc_load);
        int_high_prio <= 1'b0;
        pulse(7);
        chk("pc_load", VEC_LOW, pc_load);
        rd(ADDR_STACK, 8'h02);
        rd(ADDR_BANK, 8'h05);
        rd(ADDR_TBLAT, 8'hA5);
        wr(ADDR_INTC0, 8'hFF);
        power_mode <= MODE_FULL;
        pulse(3);
        rd(ADDR_INTC0, 8'h01);
        rd(ADDR_BANK, 8'h00);
        rd(ADDR_TBLAT, 8'h00);
        rd(ADDR_STACK, 8'h00);
        rd(ADDR_CTRL, 8'h01);
        rd(ADDR_INTC2, INTC2_RST);
        // wake request at full power is not a wake
        wr(ADDR_CAUSE, 8'h37);
        pulse(7);
        chk("pc_load_valid", 1'b0, pc_load_valid);
        chk("cause", 8'h37, reset_cause_register);
        pulse(8);
        chk("cause", 8'h3B, reset_cause_register);
        pulse(9);
        chk("cause", 8'h3F, reset_cause_register);
        repeat (5) @(negedge core_clk);
        chk("cause", 8'h3F, reset_cause_register);
        // a watchdog reset while the enable is low must be lost
        @(posedge core_clk);
        clk_en <= 1'b0;
        pulse(6);
        chk("core_reset", 1'b0, core_reset);
        chk("cause", 8'h3F, reset_cause_register);
        @(posedge core_clk);
        clk_en <= 1'b1;
        // underflow with the stack reset disabled
        wr(ADDR_CTRL, 8'h00);
        pulse(5);
        chk("core_reset", 1'b0, core_reset);
        chk("stack_flags", 2'b01, {stack_full_flag, stack_underflow_flag});
        chk("cause", 8'h3F, reset_cause_register);
        // second power-on in mid run
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk("cause", CAUSE_POR_VAL, reset_cause_register);
        chk("stack_flags", 2'b00, {stack_full_flag, stack_underflow_flag});
        rd(ADDR_CTRL, 8'h01);
        close_out();
    end
endmodule : reset_cause_status_logic_tb
